// file: hw/afd_host_port.sv
// host port of the audio frame decoder: apb registers, request handshake, flags
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
module afd_host_port
    import afd_pkg::*;
#(
    parameter int FRAME_BYTES = FIRST_FILL_BYTES,
    parameter int ANC_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoder core side
    input wire logic core_need_frame,
    input wire logic [10:0] core_frame_len,
    input wire logic hdr_valid,
    input wire logic hdr_version,
    input wire logic [1:0] hdr_rate,
    input wire logic err_layer,
    input wire logic err_sync,
    input wire logic err_crc,
    input wire logic anc_valid,
    input wire logic [7:0] anc_byte,
    output logic anc_ready,
    output logic in_valid,
    output logic [7:0] in_byte,
    output logic frame_ready,
    output logic frame_drop,
    output logic dec_enable,
    output logic dec_tick,
    output logic bass_boost_enable,
    output logic [4:0] left_volume_code,
    output logic [4:0] right_volume_code,
    output logic [4:0] low_band_gain_code,
    output logic [4:0] mid_band_gain_code,
    output logic [4:0] high_band_gain_code,
    output logic decoder_irq
);
    localparam int AW = $clog2(ANC_DEPTH);

    logic [7:0] decoder_control_reg_r;
    logic [7:0] irq_enable_reg_zero_r;
    logic [4:0] clock_divide_field_r;
    logic data_request_flag_r;
    logic frame_request_flag_r;
    logic byte_toggle_flag_r;
    logic layer_error_flag_r;
    logic sync_error_flag_r;
    logic checksum_error_flag_r;
    logic stream_version_bit_r;
    logic [1:0] sample_rate_code_r;
    logic first_fill_r;
    logic [10:0] bytes_left_r;
    logic en_d_r;
    logic [7:0] anc_mem [ANC_DEPTH];
    logic [AW:0] anc_cnt_r;
    logic [AW-1:0] anc_wp_r;
    logic [AW-1:0] anc_rp_r;
    logic wr_acc;
    logic rd_acc;
    logic st_rd;
    logic data_wr;
    logic anc_rd;
    logic anc_push;
    logic anc_pop;
    logic ancillary_ready_flag;
    logic [7:0] status_val;
    logic new_req;
    logic crc_hit;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; always answers with no wait state

    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    // flags clear at the setup edge that takes their snapshot, so a later set is never lost
    assign st_rd = psel && !penable && !pwrite && paddr == ADDR_STATUS;
    assign data_wr = wr_acc && paddr == ADDR_DATA;
    assign anc_rd = rd_acc && paddr == ADDR_ANC;
    assign dec_enable = decoder_control_reg_r[CTL_EN];
    assign bass_boost_enable = decoder_control_reg_r[CTL_BASS];

    always_comb begin
        unique case (paddr)
            ADDR_CONTROL, ADDR_STATUS, ADDR_STATUS_AUX, ADDR_DATA, ADDR_ANC,
            ADDR_LEFT, ADDR_RIGHT, ADDR_LOW, ADDR_MID, ADDR_HIGH,
            ADDR_CLKDIV, ADDR_IRQEN: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decoder_control_reg_r <= CONTROL_RST;
        end else if (wr_acc && paddr == ADDR_CONTROL) begin
            decoder_control_reg_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_reg_zero_r <= 8'h00;
        end else if (wr_acc && paddr == ADDR_IRQEN) begin
            irq_enable_reg_zero_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_divide_field_r <= CLKDIV_RST;
        end else if (wr_acc && paddr == ADDR_CLKDIV) begin
            clock_divide_field_r <= pwdata[4:0];
        end
    end

    // five gain codes share one register shape: left, right, low, mid, high
    localparam logic [7:0] GAIN_ADDR [5] = '{ADDR_LEFT, ADDR_RIGHT, ADDR_LOW,
        ADDR_MID, ADDR_HIGH};
    logic [4:0] gain_r [5];

    for (genvar i = 0; i < 5; i++) begin : g_gain
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                gain_r[i] <= GAIN_RST;
            end else if (wr_acc && paddr == GAIN_ADDR[i]) begin
                gain_r[i] <= pwdata[4:0];
            end
        end
    end

    assign left_volume_code = gain_r[0];
    assign right_volume_code = gain_r[1];
    assign low_band_gain_code = gain_r[2];
    assign mid_band_gain_code = gain_r[3];
    assign high_band_gain_code = gain_r[4];

    assign status_val = {ancillary_ready_flag, data_request_flag_r, layer_error_flag_r,
        sync_error_flag_r, checksum_error_flag_r, sample_rate_code_r, stream_version_bit_r};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                ADDR_CONTROL: prdata <= {24'h000000, decoder_control_reg_r};
                ADDR_STATUS: prdata <= {24'h000000, status_val};
                ADDR_STATUS_AUX: prdata <= {30'h0, frame_request_flag_r, byte_toggle_flag_r};
                ADDR_ANC: prdata <= {24'h000000, anc_mem[anc_rp_r]};
                ADDR_LEFT: prdata <= {27'h0, left_volume_code};
                ADDR_RIGHT: prdata <= {27'h0, right_volume_code};
                ADDR_LOW: prdata <= {27'h0, low_band_gain_code};
                ADDR_MID: prdata <= {27'h0, mid_band_gain_code};
                ADDR_HIGH: prdata <= {27'h0, high_band_gain_code};
                ADDR_CLKDIV: prdata <= {27'h0, clock_divide_field_r};
                ADDR_IRQEN: prdata <= {24'h000000, irq_enable_reg_zero_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoder clock enable

    afd_clk_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .div(clock_divide_field_r),
        .tick(dec_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // input request handshake

    // a new request opens on enable rise or when the core asks for a frame
    assign new_req = dec_enable && !frame_request_flag_r
        && (!en_d_r || (core_need_frame && !first_fill_r));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_d_r <= 1'b0;
            first_fill_r <= 1'b0;
            frame_request_flag_r <= 1'b0;
            bytes_left_r <= 11'h000;
            frame_ready <= 1'b0;
        end else begin
            en_d_r <= dec_enable;
            frame_ready <= 1'b0;
            if (!dec_enable) begin
                frame_request_flag_r <= 1'b0;
                first_fill_r <= 1'b0;
            end else if (new_req) begin
                frame_request_flag_r <= 1'b1;
                first_fill_r <= !en_d_r;
                bytes_left_r <= !en_d_r ? 11'(FRAME_BYTES) : core_frame_len;
            end else if (frame_request_flag_r && data_wr) begin
                bytes_left_r <= bytes_left_r - 11'h001;
                if (bytes_left_r <= 11'h001) begin
                    frame_request_flag_r <= 1'b0;
                    first_fill_r <= 1'b0;
                    frame_ready <= 1'b1;
                end
            end
        end
    end

    // byte passes straight to the core buffer; writes outside a request are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_valid <= 1'b0;
            in_byte <= 8'h00;
            byte_toggle_flag_r <= 1'b0;
        end else begin
            in_valid <= data_wr && frame_request_flag_r;
            if (data_wr) begin
                in_byte <= pwdata[7:0];
                byte_toggle_flag_r <= !byte_toggle_flag_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event flags; a set in the cycle of a status read wins

    assign crc_hit = err_crc && dec_enable;
    assign frame_drop = crc_hit && !decoder_control_reg_r[CTL_BADPLAY];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_request_flag_r <= 1'b0;
            layer_error_flag_r <= 1'b0;
            sync_error_flag_r <= 1'b0;
            checksum_error_flag_r <= 1'b0;
        end else begin
            data_request_flag_r <= new_req || (data_request_flag_r && !st_rd);
            layer_error_flag_r <= err_layer || (layer_error_flag_r && !st_rd);
            sync_error_flag_r <= err_sync || (sync_error_flag_r && !st_rd);
            checksum_error_flag_r <= crc_hit || (checksum_error_flag_r && !st_rd);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stream_version_bit_r <= STATUS_RST[ST_VER];
            sample_rate_code_r <= STATUS_RST[ST_FS_LO+1:ST_FS_LO];
        end else if (hdr_valid) begin
            stream_version_bit_r <= hdr_version;
            sample_rate_code_r <= hdr_rate;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ancillary byte buffer

    assign anc_ready = anc_cnt_r < (AW+1)'(ANC_DEPTH);
    assign anc_push = anc_valid && anc_ready;
    assign anc_pop = anc_rd && ancillary_ready_flag;
    assign ancillary_ready_flag = anc_cnt_r != '0;

    always_ff @(posedge pclk) begin
        if (anc_push) begin
            anc_mem[anc_wp_r] <= anc_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            anc_cnt_r <= '0;
            anc_wp_r <= '0;
            anc_rp_r <= '0;
        end else begin
            if (anc_push) begin
                anc_wp_r <= anc_wp_r + 1'b1;
            end
            if (anc_pop) begin
                anc_rp_r <= anc_rp_r + 1'b1;
            end
            if (anc_push && !anc_pop) begin
                anc_cnt_r <= anc_cnt_r + 1'b1;
            end else if (anc_pop && !anc_push) begin
                anc_cnt_r <= anc_cnt_r - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt: unmasked flags or'ed, then gated by both enables

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decoder_irq <= 1'b0;
        end else begin
            decoder_irq <= irq_enable_reg_zero_r[IEN_GLOBAL] && irq_enable_reg_zero_r[IEN_DEC]
                && ((checksum_error_flag_r && !decoder_control_reg_r[CTL_MSK_CRC])
                || (sync_error_flag_r && !decoder_control_reg_r[CTL_MSK_SYN])
                || (layer_error_flag_r && !decoder_control_reg_r[CTL_MSK_LAY])
                || (data_request_flag_r && !decoder_control_reg_r[CTL_MSK_REQ])
                || (ancillary_ready_flag && !decoder_control_reg_r[CTL_MSK_ANC]));
        end
    end
endmodule

// file: include/afd_pkg.sv
// constants and register map of the audio frame decoder host port
//
// How it works
// - decoding of a frame starts only once a whole frame sits in the input buffer
// - a need for input raises data request and frame request flags
// - frame request stays high while a frame is wanted, clears when satisfied
// - byte toggle flag inverts on every byte written to the input data port
// - first request after enable asks for 1024 bytes to fill the buffer
// - decoder clock is the pll clock divided by the five-bit divide field; code divides pclk by field plus one, 0 and 1 give full rate
// - each channel has a five-bit volume code, zero mutes
// - equalizer has low, middle and high bands split at 750 and 3300 Hz
// - each band takes a five-bit gain code, zero is full attenuation
// - bass boost enable adds 9 dB below 375 Hz
// - unsupported layer in a header sets the layer error flag
// - missing synchronization pattern sets the sync error flag
// - checksum mismatch sets checksum error flag; frame played or rejected
// - bad-frame play enable set plays bad frames, cleared skips them
// - version bit and two-bit rate code from the header are reported
// - ancillary ready flag is high while the ancillary buffer holds a byte
// - five interrupt sources, each with its own mask bit
// - a set mask bit blocks its flag from the interrupt
// - interrupt reaches the core only with decoder and global enables set
// - status read clears all event flags except ancillary ready
package afd_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_STATUS_AUX = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0C;
    localparam logic [7:0] ADDR_ANC = 8'h10;
    localparam logic [7:0] ADDR_LEFT = 8'h14;
    localparam logic [7:0] ADDR_RIGHT = 8'h18;
    localparam logic [7:0] ADDR_LOW = 8'h1C;
    localparam logic [7:0] ADDR_MID = 8'h20;
    localparam logic [7:0] ADDR_HIGH = 8'h24;
    localparam logic [7:0] ADDR_CLKDIV = 8'h28;
    localparam logic [7:0] ADDR_IRQEN = 8'h2C;
    // control register fields
    localparam int CTL_EN = 7;
    localparam int CTL_BASS = 6;
    localparam int CTL_BADPLAY = 5;
    localparam int CTL_MSK_ANC = 4;
    localparam int CTL_MSK_REQ = 3;
    localparam int CTL_MSK_LAY = 2;
    localparam int CTL_MSK_SYN = 1;
    localparam int CTL_MSK_CRC = 0;
    localparam logic [7:0] CONTROL_RST = 8'h3F;
    // status register fields
    localparam int ST_ANC = 7;
    localparam int ST_REQ = 6;
    localparam int ST_LAY = 5;
    localparam int ST_SYN = 4;
    localparam int ST_CRC = 3;
    localparam int ST_FS_LO = 1;
    localparam int ST_VER = 0;
    localparam logic [7:0] STATUS_RST = 8'h01;
    // aux status fields
    localparam int AUX_FREQ = 1;
    localparam int AUX_BREQ = 0;
    // irq enable fields
    localparam int IEN_GLOBAL = 7;
    localparam int IEN_DEC = 0;
    localparam logic [4:0] GAIN_RST = 5'h00;
    localparam logic [4:0] CLKDIV_RST = 5'h00;
    localparam int FIRST_FILL_BYTES = 1024;
endpackage

// file: hw/afd_clk_div.sv
// decoder clock enable divider
`timescale 1ns/10ps
module afd_clk_div
    import afd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] div,
    output logic tick
);
    logic [4:0] cnt_r;

    // divide factor zero or one runs at full rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 5'h00;
            tick <= 1'b0;
        end else if (cnt_r >= div || div <= 5'h01) begin
            cnt_r <= 5'h00;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 5'h01;
            tick <= 1'b0;
        end
    end
endmodule

// file: test/afd_host_port_properties.sv
// timing checks on the host port pins
`timescale 1ns/10ps
module afd_host_port_properties
    import afd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic err_crc,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    input wire logic frame_ready,
    input wire logic frame_drop,
    input wire logic dec_enable,
    input wire logic [4:0] left_volume_code
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_host_wr(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_pready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (psel && penable && paddr == 8'h30 |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (psel && penable && paddr <= ADDR_IRQEN && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("mapped access refused");
    a_byte_forward: assert property (s_host_wr(ADDR_DATA) ##1 in_valid
        |-> in_byte == $past(pwdata[7:0])) else $error("forwarded byte differs");
    a_valid_cause: assert property (in_valid
        |-> $past(psel && penable && pwrite && paddr == ADDR_DATA)) else $error("stray byte");
    a_ready_pulse: assert property (frame_ready |=> !frame_ready)
        else $error("frame ready held");
    a_ready_cause: assert property (frame_ready |-> in_valid || $past(in_valid))
        else $error("frame ready without byte");
    a_drop_cause: assert property (frame_drop |-> err_crc && dec_enable)
        else $error("drop without checksum error");
    a_gain_write: assert property (s_host_wr(ADDR_LEFT) |=>
        left_volume_code == $past(pwdata[4:0])) else $error("volume not loaded");
    a_gain_hold: assert property (!$stable(left_volume_code)
        |-> $past(psel && penable && pwrite && paddr == ADDR_LEFT)) else $error("volume drift");
endmodule
bind afd_host_port afd_host_port_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .err_crc(err_crc), .in_valid(in_valid), .in_byte(in_byte),
    .frame_ready(frame_ready), .frame_drop(frame_drop), .dec_enable(dec_enable),
    .left_volume_code(left_volume_code));

// file: test/afd_core_model.sv
// behavioural decoder core on the far side of the host port
`timescale 1ns/10ps
module afd_core_model (
    input wire logic pclk,
    input wire logic anc_ready,
    output logic core_need_frame,
    output logic [10:0] core_frame_len,
    output logic hdr_valid,
    output logic hdr_version,
    output logic [1:0] hdr_rate,
    output logic err_layer,
    output logic err_sync,
    output logic err_crc,
    output logic anc_valid,
    output logic [7:0] anc_byte
);
    initial {core_need_frame, core_frame_len, hdr_valid, hdr_version, hdr_rate} = '0;
    initial {err_layer, err_sync, err_crc, anc_valid, anc_byte} = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle need: a held level would reopen a request right after it closes
    task need(input logic [10:0] n);
        @(posedge pclk);
        core_need_frame <= 1'b1;
        core_frame_len <= n;
        @(posedge pclk);
        core_need_frame <= 1'b0;
        core_frame_len <= ~n;
    endtask
    task hdr(input logic v, input logic [1:0] r);
        @(posedge pclk);
        {hdr_valid, hdr_version, hdr_rate} <= {1'b1, v, r};
        @(posedge pclk);
        {hdr_valid, hdr_version, hdr_rate} <= {1'b0, ~v, ~r};
    endtask
    task err(input int k);
        @(posedge pclk);
        {err_layer, err_sync, err_crc} <= {k == 0, k == 1, k == 2};
        @(posedge pclk);
        {err_layer, err_sync, err_crc} <= 3'h0;
        #1;
    endtask
    task anc(input logic [7:0] b);
        @(posedge pclk);
        anc_valid <= 1'b1;
        anc_byte <= b;
        @(posedge pclk);
        while (anc_ready !== 1'b1) @(posedge pclk);
        anc_valid <= 1'b0;
        anc_byte <= ~b;
    endtask
endmodule

// file: test/tb_afd_host_port.sv
// register-level regression of the audio frame decoder host port
`timescale 1ns/10ps
module tb_afd_host_port;
    import afd_pkg::*;
    localparam int FB = 8;
    localparam logic [4:0] GV [5] = '{5'h1F, 5'h00, 5'h01, 5'h1E, 5'h02};
    logic pclk, presetn, psel, penable, pwrite, e, t0;
    logic [7:0] paddr, in_byte, anc_byte;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, core_need_frame, hdr_valid, hdr_version, err_layer, err_sync;
    logic err_crc, anc_valid, anc_ready, in_valid, frame_ready, frame_drop, dec_enable;
    logic dec_tick, bass, irq;
    logic [10:0] core_frame_len;
    logic [1:0] hdr_rate;
    logic [4:0] g [5];
    int errors = 0, comparisons = 0, n_ready = 0, n_drop = 0, n_tick = 0, k, j;
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        n_ready <= n_ready + int'(frame_ready === 1'b1);
        n_drop <= n_drop + int'(frame_drop === 1'b1);
        n_tick <= n_tick + int'(dec_tick === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////////////
    afd_host_port #(.FRAME_BYTES(FB), .ANC_DEPTH(16)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_need_frame(core_need_frame),
        .core_frame_len(core_frame_len), .hdr_valid(hdr_valid), .hdr_version(hdr_version),
        .hdr_rate(hdr_rate), .err_layer(err_layer), .err_sync(err_sync), .err_crc(err_crc),
        .anc_valid(anc_valid), .anc_byte(anc_byte), .anc_ready(anc_ready), .in_valid(in_valid),
        .in_byte(in_byte), .frame_ready(frame_ready), .frame_drop(frame_drop),
        .dec_enable(dec_enable), .dec_tick(dec_tick), .bass_boost_enable(bass),
        .left_volume_code(g[0]), .right_volume_code(g[1]), .low_band_gain_code(g[2]),
        .mid_band_gain_code(g[3]), .high_band_gain_code(g[4]), .decoder_irq(irq));
    afd_core_model core_u (.pclk(pclk), .anc_ready(anc_ready), .core_need_frame(core_need_frame),
        .core_frame_len(core_frame_len), .hdr_valid(hdr_valid), .hdr_version(hdr_version),
        .hdr_rate(hdr_rate), .err_layer(err_layer), .err_sync(err_sync), .err_crc(err_crc),
        .anc_valid(anc_valid), .anc_byte(anc_byte));
    ////////////////////////////////////////////////////////////////////////////////
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // the request stays unchanged until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        cmp(q & m, x);
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task give_verdict();
        if (errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CONTROL, 32'hFF, {24'h0, CONTROL_RST});
        rd(ADDR_STATUS, 32'hFF, {24'h0, STATUS_RST});
        apb(1'b0, 8'h30, 32'h0);
        cmp({e, q[30:0]}, 32'h80000000);
        wr(8'h30, 32'hFF);
        cmp(e, 1'b1);
        for (k = 0; k < 5; k++) begin
            wr(ADDR_LEFT + 8'(4 * k), 32'(GV[k]));
            cmp(g[k], GV[k]);
            rd(ADDR_LEFT + 8'(4 * k), 32'hFF, 32'(GV[k]));
        end
        wr(ADDR_CLKDIV, 32'h3);
        wait_cyc(4);
        j = n_tick;
        wait_cyc(40);
        cmp(n_tick - j, 10);
        rd(ADDR_CLKDIV, 32'h1F, 32'h3);
        wr(ADDR_CONTROL, 32'hDF);
        cmp({dec_enable, bass}, 2'h3);
        rd(ADDR_STATUS_AUX, 32'h2, 32'h2);
        t0 = q[0];
        rd(ADDR_STATUS, 32'h40, 32'h40);
        rd(ADDR_STATUS, 32'h40, 32'h0);
        for (k = 0; k < FB; k++) begin
            if (k == FB - 1) cmp(n_ready, 0);
            wr(ADDR_DATA, 32'hA0 + k);
            cmp({in_valid, in_byte}, {1'b1, 8'hA0 + 8'(k)});
        end
        wait_cyc(2);
        cmp(n_ready, 1);
        rd(ADDR_STATUS_AUX, 32'h3, {31'h0, t0});
        wr(ADDR_DATA, 32'h55);
        cmp(in_valid, 1'b0);
        rd(ADDR_STATUS_AUX, 32'h1, {31'h0, ~t0});
        core_u.need(11'h3);
        wait_cyc(2);
        rd(ADDR_STATUS_AUX, 32'h2, 32'h2);
        for (k = 0; k < 3; k++) wr(ADDR_DATA, 32'h10 + k);
        wait_cyc(2);
        rd(ADDR_STATUS_AUX, 32'h2, 32'h0);
        cmp(n_ready, 2);
        for (k = 0; k < 8; k++) begin
            core_u.hdr(k[2], k[1:0]);
            rd(ADDR_STATUS, 32'h7, {29'h0, k[1:0], k[2]});
        end
        for (k = 0; k < 3; k++) core_u.err(k);
        rd(ADDR_STATUS, 32'h38, 32'h38);
        rd(ADDR_STATUS, 32'h78, 32'h0);
        j = n_drop;
        core_u.err(2);
        cmp(n_drop - j, 1);
        wr(ADDR_CONTROL, 32'hFF);
        core_u.err(2);
        cmp(n_drop - j, 1);
        core_u.anc(8'h5A);
        core_u.anc(8'hC3);
        rd(ADDR_STATUS, 32'h80, 32'h80);
        rd(ADDR_STATUS, 32'h80, 32'h80);
        rd(ADDR_ANC, 32'hFF, 32'h5A);
        rd(ADDR_STATUS, 32'h80, 32'h80);
        rd(ADDR_ANC, 32'hFF, 32'hC3);
        rd(ADDR_STATUS, 32'h80, 32'h0);
        cmp(anc_ready, 1'b1);
        wr(ADDR_IRQEN, 32'h81);
        wr(ADDR_CONTROL, 32'hFD);
        core_u.err(1);
        wait_cyc(3);
        cmp(irq, 1'b1);
        wait_cyc(3);
        cmp(irq, 1'b1);
        rd(ADDR_STATUS, 32'h10, 32'h10);
        wait_cyc(3);
        cmp(irq, 1'b0);
        core_u.err(0);
        wait_cyc(3);
        cmp(irq, 1'b0);
        wr(ADDR_IRQEN, 32'h01);
        core_u.err(1);
        wait_cyc(3);
        cmp(irq, 1'b0);
        give_verdict();
    end
endmodule
